// [i2cm_controller.sv]
`timescale 1ns/1ps
module i2cm_controller
  import i2cm_pkg::*;
#(
  parameter int BRG_W = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Control and status registers
  input wire logic ctrl_wr_i,
  input wire logic [REG_W-1:0] ctrl_wdata_i,
  output logic [REG_W-1:0] bus_control_register_o,
  input wire logic stat_wr_i,
  input wire logic [REG_W-1:0] stat_wdata_i,
  output logic [REG_W-1:0] bus_status_register_o,
  // Data registers and configuration
  input wire logic tx_wr_i,
  input wire logic [BYTE_W-1:0] tx_data_i,
  input wire logic rx_rd_i,
  output logic [BYTE_W-1:0] receive_holding_buffer_o,
  input wire logic [ADDR_W-1:0] own_slave_address_i,
  input wire logic [BRG_W-1:0] baud_reload_value_i,
  output logic irq_o,
  // Bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  typedef struct packed {
    logic [REG_W-1:0] ctrl;
    logic [REG_W-1:0] st;
    logic [BYTE_W-1:0] rsr;
    logic [BYTE_W-1:0] rcv;
    logic [BYTE_W-1:0] trn;
    logic [BYTE_W-1:0] tsr;
    i2cm_slave_type s_state;
    i2cm_slave_type s_next;
    logic [3:0] s_cnt;
    logic s_ack;
    logic s_drv;
    logic prior;
    logic s_sda_low;
    i2cm_master_type m_state;
    logic m_half;
    logic m_rx;
    logic [3:0] m_bit;
    logic [BRG_W-1:0] m_cnt;
    logic [BYTE_W-1:0] m_tsr;
    logic m_scl_low;
    logic m_sda_low;
    logic scl_q;
    logic sda_q;
    logic irq;
    logic scl_oe;
    logic sda_oe;
  } i2cm_state_type;

  i2cm_state_type r;
  i2cm_state_type next_r;

  logic rise;
  logic fall;
  logic start_seen;
  logic stop_seen;
  logic slv_go;
  logic byte_done;
  logic [BYTE_W-1:0] byte_in;

  // Bus edge and condition detection
  assign rise = scl_i & ~r.scl_q;
  assign fall = ~scl_i & r.scl_q;
  assign start_seen = scl_i & r.scl_q & r.sda_q & ~sda_i;
  assign stop_seen = scl_i & r.scl_q & ~r.sda_q & sda_i;
  assign byte_in = {r.rsr[6:0], sda_i};
  assign slv_go = r.ctrl[CTL_EN] & (r.m_state == MS_IDLE) & ~start_seen & ~stop_seen;
  assign byte_done = slv_go & rise & (r.s_cnt == LAST_BIT);

  always_comb begin
    next_r = r;
    next_r.irq = 1'h0;
    next_r.scl_q = scl_i;
    next_r.sda_q = sda_i;
    // Processor side writes come first so hardware sets win
    if (ctrl_wr_i) next_r.ctrl = ctrl_wdata_i;
    if (stat_wr_i) next_r.st[REG_W-1:RO_BITS] = stat_wdata_i[REG_W-1:RO_BITS];
    if (rx_rd_i) next_r.st[ST_RBF] = 1'h0;
    if (tx_wr_i && !r.st[ST_TBF]) begin
      next_r.trn = tx_data_i;
      next_r.st[ST_TBF] = 1'h1;
    end
    if (!r.ctrl[CTL_EN]) begin
      next_r.s_state = SL_IDLE;
      next_r.m_state = MS_IDLE;
      next_r.m_scl_low = 1'h0;
      next_r.m_sda_low = 1'h0;
      next_r.s_sda_low = 1'h0;
    end else begin
      // Slave engine
      if (r.m_state == MS_IDLE) begin
        if (stop_seen) begin
          next_r.s_state = SL_IDLE;
          next_r.prior = 1'h0;
          next_r.s_sda_low = 1'h0;
        end else if (start_seen) begin
          next_r.s_state = SL_ADDR;
          next_r.s_cnt = 4'h0;
          next_r.s_sda_low = 1'h0;
        end else begin
          unique case (r.s_state)
            SL_IDLE: begin
            end
            SL_ADDR, SL_ADDR_LO, SL_RX: begin
              if (rise) begin
                next_r.rsr = byte_in;
                next_r.s_cnt = r.s_cnt + 4'h1;
                if (r.s_cnt == LAST_BIT) begin
                  next_r.s_cnt = 4'h0;
                  next_r.s_state = SL_ACK_OUT;
                  next_r.s_drv = 1'h0;
                  next_r.s_ack = 1'h0;
                  next_r.s_next = SL_IDLE;
                  if (r.s_state == SL_ADDR && !r.ctrl[CTL_TEN_BIT_ADDRESS_SELECT]) begin
                    if (byte_in[7:1] == own_slave_address_i[6:0]) begin
                      next_r.s_ack = 1'h1;
                      next_r.irq = 1'h1;
                      next_r.st[ST_RW] = byte_in[0];
                      next_r.s_next = byte_in[0] ? SL_TX_WAIT : SL_RX;
                    end
                  end else if (r.s_state == SL_ADDR) begin
                    next_r.st[ST_TEN_BIT_MATCH_FLAG] = 1'h0;
                    if (byte_in[7:3] == TEN_PREFIX && byte_in[2:1] == own_slave_address_i[9:8]) begin
                      if (!byte_in[0]) begin
                        next_r.s_ack = 1'h1;
                        next_r.irq = 1'h1;
                        next_r.s_next = SL_ADDR_LO;
                      end else if (r.prior) begin
                        next_r.s_ack = 1'h1;
                        next_r.irq = 1'h1;
                        next_r.st[ST_RW] = 1'h1;
                        next_r.st[ST_TEN_BIT_MATCH_FLAG] = 1'h1;
                        next_r.s_next = SL_TX_WAIT;
                      end
                    end
                  end else if (r.s_state == SL_ADDR_LO) begin
                    if (byte_in == own_slave_address_i[7:0]) begin
                      next_r.s_ack = 1'h1;
                      next_r.irq = 1'h1;
                      next_r.st[ST_TEN_BIT_MATCH_FLAG] = 1'h1;
                      next_r.prior = 1'h1;
                      next_r.st[ST_RW] = 1'h0;
                      next_r.s_next = SL_RX;
                    end else begin
                      next_r.st[ST_TEN_BIT_MATCH_FLAG] = 1'h0;
                    end
                  end else begin
                    next_r.irq = 1'h1;
                    next_r.s_next = SL_RX;
                    if (next_r.st[ST_RBF]) begin
                      next_r.st[ST_OV] = 1'h1;
                    end else begin
                      next_r.rcv = byte_in;
                      next_r.st[ST_RBF] = 1'h1;
                      next_r.s_ack = ~next_r.st[ST_OV];
                    end
                  end
                end
              end
            end
            SL_ACK_OUT: begin
              if (fall) begin
                if (!r.s_drv) begin
                  next_r.s_drv = 1'h1;
                  next_r.s_sda_low = r.s_ack;
                end else begin
                  next_r.s_sda_low = 1'h0;
                  next_r.s_state = r.s_ack ? r.s_next : SL_IDLE;
                  if (r.s_ack && r.s_next == SL_TX_WAIT && !next_r.st[ST_TBF]) next_r.ctrl[CTL_REL] = 1'h0;
                end
              end
            end
            SL_TX_WAIT: begin
              if (next_r.st[ST_TBF] && next_r.ctrl[CTL_REL]) begin
                next_r.tsr = {next_r.trn[6:0], 1'h0};
                next_r.s_sda_low = ~next_r.trn[7];
                next_r.st[ST_TBF] = 1'h0;
                next_r.s_cnt = 4'h1;
                next_r.s_state = SL_TX;
              end
            end
            SL_TX: begin
              if (fall) begin
                if (r.s_cnt == ACK_BIT) begin
                  next_r.s_sda_low = 1'h0;
                  next_r.s_state = SL_ACK_IN;
                end else begin
                  next_r.s_sda_low = ~r.tsr[7];
                  next_r.tsr = {r.tsr[6:0], 1'h0};
                  next_r.s_cnt = r.s_cnt + 4'h1;
                end
              end
            end
            SL_ACK_IN: begin
              if (rise) next_r.st[ST_ACKSTAT] = sda_i;
              if (fall) begin
                next_r.irq = 1'h1;
                next_r.s_cnt = 4'h0;
                next_r.s_state = r.st[ST_ACKSTAT] ? SL_IDLE : SL_TX_WAIT;
                if (!r.st[ST_ACKSTAT] && !next_r.st[ST_TBF]) next_r.ctrl[CTL_REL] = 1'h0;
              end
            end
          endcase
        end
      end
      // Master engine
      unique case (r.m_state)
        MS_IDLE: begin
          if (next_r.ctrl[CTL_SEN] && scl_i && sda_i && r.s_state == SL_IDLE) begin
            next_r.m_sda_low = 1'h1;
            next_r.m_cnt = baud_reload_value_i;
            next_r.m_state = MS_START;
          end
        end
        MS_START: begin
          if (r.m_cnt == '0) begin
            next_r.m_scl_low = 1'h1;
            next_r.ctrl[CTL_SEN] = 1'h0;
            next_r.m_state = MS_HOLD;
            next_r.irq = 1'h1;
          end else begin
            next_r.m_cnt = r.m_cnt - 1'h1;
          end
        end
        MS_HOLD: begin
          next_r.m_bit = 4'h0;
          next_r.m_half = 1'h0;
          next_r.m_cnt = baud_reload_value_i;
          if (next_r.ctrl[CTL_PEN]) begin
            next_r.m_sda_low = 1'h1;
            next_r.m_state = MS_STOP;
          end else if (next_r.ctrl[CTL_RSEN]) begin
            next_r.m_sda_low = 1'h0;
            next_r.m_state = MS_RESTART;
          end else if (next_r.ctrl[CTL_RCEN] || next_r.st[ST_TBF]) begin
            // Address bytes of either width go out as ordinary bytes
            next_r.m_rx = next_r.ctrl[CTL_RCEN];
            next_r.m_tsr = next_r.ctrl[CTL_RCEN] ? 8'hff : next_r.trn;
            if (!next_r.ctrl[CTL_RCEN]) next_r.st[ST_TBF] = 1'h0;
            next_r.m_sda_low = ~next_r.m_tsr[7];
            next_r.m_state = MS_BYTE;
          end
        end
        MS_STOP, MS_RESTART: begin
          if (r.m_cnt == '0) begin
            next_r.m_cnt = baud_reload_value_i;
            next_r.m_bit = r.m_bit + 4'h1;
            if (r.m_bit == 4'h0) begin
              next_r.m_scl_low = 1'h0;
            end else if (r.m_state == MS_STOP) begin
              next_r.m_sda_low = 1'h0;
              next_r.ctrl[CTL_PEN] = 1'h0;
              next_r.m_state = MS_IDLE;
              next_r.irq = 1'h1;
            end else if (r.m_bit == 4'h1) begin
              next_r.m_sda_low = 1'h1;
            end else begin
              next_r.m_scl_low = 1'h1;
              next_r.ctrl[CTL_RSEN] = 1'h0;
              next_r.m_state = MS_HOLD;
              next_r.irq = 1'h1;
            end
          end else begin
            next_r.m_cnt = r.m_cnt - 1'h1;
          end
        end
        MS_BYTE: begin
          if (!r.m_half) begin
            if (r.m_cnt == '0) begin
              next_r.m_scl_low = 1'h0;
              next_r.m_half = 1'h1;
              next_r.m_cnt = baud_reload_value_i;
            end else begin
              next_r.m_cnt = r.m_cnt - 1'h1;
            end
          end else if (rise) begin
            next_r.m_tsr = {r.m_tsr[6:0], 1'h1};
            if (r.m_bit == ACK_BIT) begin
              if (!r.m_rx) next_r.st[ST_ACKSTAT] = sda_i;
            end else if (r.m_rx) begin
              next_r.rsr = byte_in;
            end else if (!r.m_sda_low && !sda_i) begin
              next_r.st[ST_BCL] = 1'h1;
              next_r.m_scl_low = 1'h0;
              next_r.m_sda_low = 1'h0;
              next_r.m_state = MS_IDLE;
              next_r.irq = 1'h1;
            end
          end else if (scl_i) begin
            if (r.m_cnt == '0) begin
              next_r.m_scl_low = 1'h1;
              next_r.m_half = 1'h0;
              next_r.m_cnt = baud_reload_value_i;
              next_r.m_bit = r.m_bit + 4'h1;
              if (r.m_bit == ACK_BIT) begin
                next_r.m_sda_low = 1'h0;
                next_r.m_state = MS_HOLD;
                next_r.irq = 1'h1;
                if (r.m_rx) begin
                  next_r.ctrl[CTL_RCEN] = 1'h0;
                  if (next_r.st[ST_RBF]) begin
                    next_r.st[ST_OV] = 1'h1;
                  end else begin
                    next_r.rcv = r.rsr;
                    next_r.st[ST_RBF] = 1'h1;
                  end
                end
              end else if (r.m_bit == LAST_BIT) begin
                next_r.m_sda_low = r.m_rx & ~next_r.ctrl[CTL_ACKDT];
              end else begin
                next_r.m_sda_low = ~r.m_tsr[7];
              end
            end else begin
              next_r.m_cnt = r.m_cnt - 1'h1;
            end
          end
        end
      endcase
    end
    next_r.st[ST_SACT] = next_r.s_state != SL_IDLE;
    next_r.st[ST_MACT] = next_r.m_state != MS_IDLE;
    // Both lines are open drain: enable means pull low
    next_r.scl_oe = next_r.m_scl_low | (~next_r.ctrl[CTL_REL] & (next_r.s_state != SL_IDLE));
    next_r.sda_oe = next_r.m_sda_low | next_r.s_sda_low;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.ctrl <= CTL_RST;
      r.st <= STAT_RST;
    end else begin
      r <= next_r;
    end
  end

  assign bus_control_register_o = r.ctrl;
  assign bus_status_register_o = r.st;
  assign receive_holding_buffer_o = r.rcv;
  assign irq_o = r.irq;
  assign scl_o = 1'h0;
  assign sda_o = 1'h0;
  assign scl_oe_o = r.scl_oe;
  assign sda_oe_o = r.sda_oe;

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_ctrl_rw;
    logic [REG_W-1:0] v;
    (ctrl_wr_i, v = ctrl_wdata_i) |=> bus_control_register_o[15:13] == v[15:13] && bus_control_register_o[11:6] == v[11:6];
  endproperty
  a_ctrl_write_back: assert property (p_ctrl_rw) else $error("control write not held");

  property p_stat_up;
    logic [REG_W-1:0] v;
    (stat_wr_i && r.s_state == SL_IDLE && r.m_state == MS_IDLE, v = stat_wdata_i)
      |=> bus_status_register_o[REG_W-1:RO_BITS] == v[REG_W-1:RO_BITS];
  endproperty
  a_stat_upper_rw: assert property (p_stat_up) else $error("status upper bits not writable");

  property p_stat_lo;
    logic [REG_W-1:0] v;
    (stat_wr_i && !rx_rd_i && !tx_wr_i && r.s_state == SL_IDLE && r.m_state == MS_IDLE, v = bus_status_register_o)
      |=> bus_status_register_o[3:0] == v[3:0];
  endproperty
  a_stat_low_ro: assert property (p_stat_lo) else $error("status low bits written");

  a_rx_load_pulse: assert property ($rose(bus_status_register_o[ST_RBF]) |-> irq_o)
    else $error("byte loaded without interrupt");

  a_overflow_no_load: assert property ($rose(bus_status_register_o[ST_OV]) && !$past(stat_wr_i)
    |-> irq_o && $stable(receive_holding_buffer_o)) else $error("overflow loaded buffer");

  a_seven_bit_match: assert property (byte_done && r.s_state == SL_ADDR && !r.ctrl[CTL_TEN_BIT_ADDRESS_SELECT]
    && r.rsr[6:0] == own_slave_address_i[6:0] |=> r.s_state == SL_ACK_OUT && r.s_ack && irq_o)
    else $error("seven bit address not acknowledged");

  a_ten_prefix_match: assert property (byte_done && r.s_state == SL_ADDR && r.ctrl[CTL_TEN_BIT_ADDRESS_SELECT] && !sda_i
    && r.rsr[6:2] == TEN_PREFIX && r.rsr[1:0] == own_slave_address_i[9:8]
    |=> r.s_next == SL_ADDR_LO && r.s_ack ##2 r.s_state != SL_ADDR_LO) else $error("prefix not matched");

  a_ten_low_hit: assert property (byte_done && r.s_state == SL_ADDR_LO && byte_in == own_slave_address_i[7:0]
    |=> bus_status_register_o[ST_TEN_BIT_MATCH_FLAG] && irq_o && r.s_next == SL_RX) else $error("low byte hit lost");

  a_ten_low_miss: assert property (byte_done && r.s_state == SL_ADDR_LO && byte_in != own_slave_address_i[7:0]
    |=> !bus_status_register_o[ST_TEN_BIT_MATCH_FLAG] && !r.s_ack) else $error("low byte miss acknowledged");

  a_arb_release: assert property ($rose(bus_status_register_o[ST_BCL]) && !$past(stat_wr_i)
    |-> !sda_oe_o && r.m_state == MS_IDLE) else $error("bus kept after collision");

  a_hold_clock: assert property (!bus_control_register_o[CTL_REL] && r.s_state != SL_IDLE |-> scl_oe_o)
    else $error("clock not held");

  c_seven_match: cover property (r.s_state == SL_ACK_OUT && r.s_ack && r.s_next == SL_RX);
  c_ten_full: cover property ($rose(bus_status_register_o[ST_TEN_BIT_MATCH_FLAG]));
  c_arb_lost: cover property ($rose(bus_status_register_o[ST_BCL]));
  c_overflow: cover property ($rose(bus_status_register_o[ST_OV]));

endmodule : i2cm_controller

// [i2cm_pkg.sv]
package i2cm_pkg;
  // Register and field widths
  localparam int REG_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 10;
  // Control bit positions
  localparam int CTL_EN = 15;
  localparam int CTL_REL = 12;
  localparam int CTL_TEN_BIT_ADDRESS_SELECT = 10;
  localparam int CTL_ACKDT = 5;
  localparam int CTL_RCEN = 3;
  localparam int CTL_PEN = 2;
  localparam int CTL_RSEN = 1;
  localparam int CTL_SEN = 0;
  // Status bit positions
  localparam int ST_TBF = 0;
  localparam int ST_RBF = 1;
  localparam int ST_RW = 2;
  localparam int ST_ACKSTAT = 3;
  localparam int ST_SACT = 4;
  localparam int ST_MACT = 5;
  localparam int RO_BITS = 6;
  localparam int ST_OV = 6;
  localparam int ST_TEN_BIT_MATCH_FLAG = 8;
  localparam int ST_BCL = 10;
  // Reset values and fixed codes
  localparam logic [REG_W-1:0] CTL_RST = 16'h1000;
  localparam logic [REG_W-1:0] STAT_RST = 16'h0000;
  localparam logic [4:0] TEN_PREFIX = 5'h1e;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // Engine states
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_ADDR_LO, SL_RX, SL_ACK_OUT, SL_TX_WAIT, SL_TX, SL_ACK_IN}
    i2cm_slave_type;
  typedef enum logic [2:0] {MS_IDLE, MS_START, MS_HOLD, MS_BYTE, MS_STOP, MS_RESTART} i2cm_master_type;
endpackage : i2cm_pkg

// [i2cm_bus_master.sv]
`timescale 1ns/1ps
module i2cm_bus_master (
  // Clock and resolved data line
  input wire logic sys_clk_i,
  input wire logic sda_i,
  // Driven lines, high means released to the pull-up
  output logic scl_o,
  output logic sda_o
);
  int half_period = 10;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : wait_cyc
  task automatic start_cond();
    sda_o = 1'b1;
    scl_o = 1'b1;
    wait_cyc(half_period);
    sda_o = 1'b0;
    wait_cyc(half_period);
    scl_o = 1'b0;
    wait_cyc(2);
  endtask : start_cond
  task automatic stop_cond();
    sda_o = 1'b0;
    wait_cyc(half_period);
    scl_o = 1'b1;
    wait_cyc(half_period);
    sda_o = 1'b1;
    wait_cyc(half_period);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] data, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o = data[i];
      wait_cyc(half_period);
      scl_o = 1'b1;
      wait_cyc(half_period);
      scl_o = 1'b0;
      wait_cyc(2);
    end
    sda_o = 1'b1;
    wait_cyc(half_period);
    scl_o = 1'b1;
    wait_cyc(half_period / 2);
    ack = ~sda_i;
    wait_cyc(half_period - half_period / 2);
    scl_o = 1'b0;
    wait_cyc(2);
  endtask : send_byte
  task automatic recv_byte(input logic nack, output logic [7:0] data);
    for (int i = 7; i >= 0; i--) begin
      sda_o = 1'b1;
      wait_cyc(half_period);
      scl_o = 1'b1;
      wait_cyc(half_period / 2);
      data[i] = sda_i;
      wait_cyc(half_period - half_period / 2);
      scl_o = 1'b0;
      wait_cyc(2);
    end
    sda_o = nack;
    wait_cyc(half_period);
    scl_o = 1'b1;
    wait_cyc(half_period);
    scl_o = 1'b0;
    wait_cyc(2);
  endtask : recv_byte
endmodule : i2cm_bus_master

// [i2c_master_slave_addressing_bench.sv]
`timescale 1ns/1ps
module i2c_master_slave_addressing_bench;
  import i2cm_pkg::*;
  // Clock, reset and register ports
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ctrl_wr = 1'b0;
  logic [REG_W-1:0] ctrl_wdata = 16'h0000;
  logic [REG_W-1:0] ctrl_q;
  logic stat_wr = 1'b0;
  logic [REG_W-1:0] stat_wdata = 16'h0000;
  logic [REG_W-1:0] stat_q;
  logic rx_rd = 1'b0;
  logic [BYTE_W-1:0] rx_q;
  logic [ADDR_W-1:0] own_addr = 10'h2b5;
  logic irq;
  logic tx_wr = 1'b0;
  logic [BYTE_W-1:0] tx_data = 8'h00;
  logic [BYTE_W-1:0] rd_byte;
  // Bus lines
  logic scl_oe, sda_oe, m_scl, m_sda, scl_line, sda_line;
  logic ack;
  int err_count = 0;
  int cmp_count = 0;
  int irq_cnt = 0;
  int base;
  always #10 sys_clk_i = ~sys_clk_i;
  assign scl_line = m_scl & ~scl_oe;
  assign sda_line = m_sda & ~sda_oe;
  always @(posedge sys_clk_i) if (irq === 1'b1) irq_cnt++;
  i2cm_controller dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(ctrl_wdata), .bus_control_register_o(ctrl_q),
    .stat_wr_i(stat_wr), .stat_wdata_i(stat_wdata), .bus_status_register_o(stat_q),
    .tx_wr_i(tx_wr), .tx_data_i(tx_data), .rx_rd_i(rx_rd), .receive_holding_buffer_o(rx_q),
    .own_slave_address_i(own_addr), .baud_reload_value_i(16'h0003), .irq_o(irq),
    .scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe)
  );
  i2cm_bus_master bm (.sys_clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(m_scl), .sda_o(m_sda));
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic wr_ctrl(input logic [15:0] v);
    @(negedge sys_clk_i);
    ctrl_wdata = v;
    ctrl_wr = 1'b1;
    @(negedge sys_clk_i);
    ctrl_wr = 1'b0;
  endtask : wr_ctrl
  task automatic wr_stat(input logic [15:0] v);
    @(negedge sys_clk_i);
    stat_wdata = v;
    stat_wr = 1'b1;
    @(negedge sys_clk_i);
    stat_wr = 1'b0;
  endtask : wr_stat
  task automatic wr_tx(input logic [7:0] v);
    @(negedge sys_clk_i);
    tx_data = v;
    tx_wr = 1'b1;
    @(negedge sys_clk_i);
    tx_wr = 1'b0;
  endtask : wr_tx
  task automatic rd_rx();
    @(negedge sys_clk_i);
    rx_rd = 1'b1;
    @(negedge sys_clk_i);
    rx_rd = 1'b0;
  endtask : rd_rx
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    chk_word(ctrl_q, CTL_RST, "control reset");
    chk_word(stat_q, STAT_RST, "status reset");
    wr_ctrl(16'h5a50);
    chk_word(ctrl_q, 16'h5a50, "control readback");
    wr_stat(16'hffff);
    chk_word(stat_q, 16'hffc0, "status low bits read-only");
    wr_stat(16'h0000);
    chk_word(stat_q, 16'h0000, "status cleared");
    $display("Test registers done");
    wr_ctrl(16'h9000);
    base = irq_cnt;
    bm.start_cond();
    bm.send_byte(8'h6a, ack);
    chk_bit(ack, 1'b1, "7-bit address ack");
    chk_word(16'(irq_cnt - base), 16'h0001, "address irq");
    chk_bit(stat_q[ST_SACT], 1'b1, "slave active");
    bm.send_byte(8'ha5, ack);
    chk_bit(ack, 1'b1, "data ack");
    chk_word({8'h00, rx_q}, 16'h00a5, "holding buffer");
    chk_bit(stat_q[ST_RBF], 1'b1, "rx full");
    chk_word(16'(irq_cnt - base), 16'h0002, "data irq");
    bm.send_byte(8'h3c, ack);
    chk_bit(ack, 1'b0, "overflow nack");
    chk_bit(stat_q[ST_OV], 1'b1, "overflow flag");
    chk_word({8'h00, rx_q}, 16'h00a5, "buffer kept");
    chk_word(16'(irq_cnt - base), 16'h0003, "overflow irq");
    bm.stop_cond();
    rd_rx();
    wr_stat(16'h0000);
    chk_word(stat_q & 16'h0042, 16'h0000, "flags cleared");
    base = irq_cnt;
    bm.start_cond();
    bm.send_byte(8'h6c, ack);
    chk_bit(ack, 1'b0, "7-bit mismatch nack");
    chk_word(16'(irq_cnt - base), 16'h0000, "no irq on mismatch");
    bm.stop_cond();
    base = irq_cnt;
    bm.start_cond();
    bm.send_byte(8'h6b, ack);
    chk_bit(ack, 1'b1, "read address ack");
    chk_bit(stat_q[ST_RW], 1'b1, "read direction");
    chk_bit(ctrl_q[CTL_REL], 1'b0, "clock release cleared");
    chk_bit(scl_oe, 1'b1, "clock held");
    wr_tx(8'h5a);
    chk_bit(stat_q[ST_TBF], 1'b1, "tx full");
    wr_ctrl(16'h9000);
    chk_bit(scl_oe, 1'b0, "clock freed");
    chk_bit(stat_q[ST_TBF], 1'b0, "tx taken");
    bm.recv_byte(1'b1, rd_byte);
    chk_word({8'h00, rd_byte}, 16'h005a, "slave transmit byte");
    chk_word(16'(irq_cnt - base), 16'h0002, "transmit irqs");
    bm.stop_cond();
    $display("Test 7-bit slave done");
    bm.half_period = 6;
    wr_ctrl(16'h9400);
    base = irq_cnt;
    bm.start_cond();
    bm.send_byte(8'hf4, ack);
    chk_bit(ack, 1'b1, "10-bit first byte ack");
    chk_bit(stat_q[ST_TEN_BIT_MATCH_FLAG], 1'b0, "partial match");
    bm.send_byte(8'hb5, ack);
    chk_bit(ack, 1'b1, "10-bit low byte ack");
    chk_bit(stat_q[ST_TEN_BIT_MATCH_FLAG], 1'b1, "full match flag");
    chk_word(16'(irq_cnt - base), 16'h0002, "10-bit irqs");
    bm.stop_cond();
    bm.start_cond();
    bm.send_byte(8'hf4, ack);
    bm.send_byte(8'hb4, ack);
    chk_bit(ack, 1'b0, "low byte mismatch nack");
    chk_bit(stat_q[ST_TEN_BIT_MATCH_FLAG], 1'b0, "flag cleared");
    bm.stop_cond();
    bm.start_cond();
    bm.send_byte(8'hf2, ack);
    chk_bit(ack, 1'b0, "upper bits mismatch nack");
    bm.stop_cond();
    $display("Test 10-bit slave done");
    base = irq_cnt;
    wr_ctrl(16'h9001);
    repeat (10) @(negedge sys_clk_i);
    chk_bit(scl_oe, 1'b1, "master start holds clock");
    bm.sda_o = 1'b0;
    wr_tx(8'hff);
    repeat (20) @(negedge sys_clk_i);
    chk_bit(stat_q[ST_BCL], 1'b1, "collision flag");
    chk_bit(sda_oe | scl_oe | stat_q[ST_MACT], 1'b0, "bus released");
    chk_word(16'(irq_cnt - base), 16'h0002, "master irqs");
    bm.sda_o = 1'b1;
    wr_stat(16'h0000);
    $display("Test master collision done");
    print_verdict();
  end
endmodule : i2c_master_slave_addressing_bench
